//--- rtl/ext_bus_pkg.sv
// Contract
// - write strobe driven only while master
// - ignore acknowledge unless master and active
// - acknowledge high extends cycle without limit
// - cycle ends one clock after acknowledge
// - wait count is larger of both
// - zero wait states never extended
// - select bit picks sync or async acknowledge
// - fast clocks need internal acknowledge synchroniser
// - request follows external bus need or hold bit, not mastership
// - request may drop while still master
// - hold bit keeps request, standby rules
// - reset drops request, enters slave state
// - after grant wait busy free, assert busy
// - grant withdrawn releases at cycle end
// - async arbitration synchronises grant and busy
// - busy marks active bus, retaken after free
// - master may park holding busy asserted
// - busy released by driving high then floating
package ext_bus_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // field widths and reset values
  localparam int WAIT_W            = 4;
  localparam logic [3:0] WAIT_RST  = 4'h1;
  localparam int SYNC_STAGES       = 2;
  localparam int PULLUP_CYCLES     = 1;

  ////////////////////////////////////////////////////////////////////////////
  // arbitration states
  typedef enum logic [1:0] {
    ARB_SLAVE   = 2'b00,
    ARB_WAIT_BB = 2'b01,
    ARB_MASTER  = 2'b10,
    ARB_RELEASE = 2'b11
  } arb_state_t;

  // bus cycle states
  typedef enum logic [1:0] {
    CYC_IDLE  = 2'b00,
    CYC_WAIT  = 2'b01,
    CYC_ACK   = 2'b10,
    CYC_DONE  = 2'b11
  } cyc_state_t;

endpackage

//--- rtl/sync_select.sv
`timescale 1ns/1ps
// optional two-stage synchroniser with a bypass for synchronous inputs
module sync_select #(
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // data
  input  wire logic din,
  input  wire logic sync_en,
  output logic      dout
);

  logic [STAGES-1:0] stage_q;
  logic [STAGES-1:0] stage_d;

  // shift the level through the chain
  always_comb begin
    stage_d = {stage_q[STAGES-2:0], din};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage_q <= {STAGES{1'b1}};
    end else begin
      stage_q <= stage_d;
    end
  end

  // only the last stage is seen when synchronising
  assign dout = sync_en ? stage_q[STAGES-1] : din;

endmodule

//--- rtl/wait_counter.sv
`timescale 1ns/1ps
// down counter of programmed wait states
module wait_counter #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              expired
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // load at cycle start, then count down to zero
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = count;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == '0) && !load;

endmodule

//--- rtl/ext_bus_ctrl.sv
`timescale 1ns/1ps
// write strobe, acknowledge stretching and multi-master arbitration
module ext_bus_ctrl #(
  parameter int WAIT_W = ext_bus_pkg::WAIT_W
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // configuration
  input  wire logic [WAIT_W-1:0] wait_states,
  input  wire logic              request_hold,
  input  wire logic              ack_sync_select,
  input  wire logic              async_arb_enable,
  input  wire logic              standby,
  // core access request
  input  wire logic              ext_req,
  input  wire logic              ext_write,
  output logic                   ext_done,
  output logic                   is_master,
  // external pins
  input  wire logic              transfer_ack_n,
  input  wire logic              bus_grant_n,
  input  wire logic              bus_busy_n_in,
  output logic                   bus_busy_n_out,
  output logic                   bus_busy_n_oe,
  output logic                   bus_request_n,
  output logic                   write_strobe_n_out,
  output logic                   write_strobe_n_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic ack_n_s;
  logic grant_n_s;
  logic busy_n_s;

  // acknowledge path chosen by the select bit
  sync_select #(.STAGES(ext_bus_pkg::SYNC_STAGES)) u_ack_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (transfer_ack_n),
    .sync_en (ack_sync_select),
    .dout    (ack_n_s)
  );

  // grant and busy synchronised when async arbitration enabled
  sync_select #(.STAGES(ext_bus_pkg::SYNC_STAGES)) u_bg_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (bus_grant_n),
    .sync_en (async_arb_enable),
    .dout    (grant_n_s)
  );

  sync_select #(.STAGES(ext_bus_pkg::SYNC_STAGES)) u_bb_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (bus_busy_n_in),
    .sync_en (async_arb_enable),
    .dout    (busy_n_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // arbitration state
  ext_bus_pkg::arb_state_t arb_q;
  ext_bus_pkg::arb_state_t arb_d;
  ext_bus_pkg::cyc_state_t cyc_q;
  ext_bus_pkg::cyc_state_t cyc_d;
  logic                    req_n_q;
  logic                    req_n_d;
  logic                    bb_oe_q;
  logic                    bb_oe_d;
  logic                    bb_out_q;
  logic                    bb_out_d;
  logic                    wr_q;
  logic                    wr_d;
  logic                    cyc_end;
  logic                    cyc_active;

  assign cyc_active = (cyc_q != ext_bus_pkg::CYC_IDLE);
  assign cyc_end    = (cyc_q == ext_bus_pkg::CYC_DONE);

  // request, arbitration states and busy drive
  always_comb begin
    arb_d    = arb_q;
    req_n_d  = req_n_q;
    bb_oe_d  = bb_oe_q;
    bb_out_d = bb_out_q;
    if (standby) begin
      if (!request_hold) begin
        req_n_d = 1'b1;
      end
    end else begin
      // external need or hold bit counts, mastership irrelevant
      req_n_d = !(ext_req || request_hold);
    end
    unique case (arb_q)
      ext_bus_pkg::ARB_SLAVE: begin
        bb_oe_d = 1'b0;
        if (!grant_n_s && !req_n_q) begin
          arb_d = ext_bus_pkg::ARB_WAIT_BB;
        end
      end
      ext_bus_pkg::ARB_WAIT_BB: begin
        if (grant_n_s) begin
          arb_d = ext_bus_pkg::ARB_SLAVE;
        end else if (busy_n_s) begin
          arb_d    = ext_bus_pkg::ARB_MASTER;
          bb_oe_d  = 1'b1;
          bb_out_d = 1'b0;
        end
      end
      ext_bus_pkg::ARB_MASTER: begin
        // parked: busy kept while grant stays, whatever the request
        if (grant_n_s && (!cyc_active || cyc_end)) begin
          arb_d    = ext_bus_pkg::ARB_RELEASE;
          bb_out_d = 1'b1;
        end
      end
      ext_bus_pkg::ARB_RELEASE: begin
        // high was driven one cycle, now float to pull-up
        arb_d   = ext_bus_pkg::ARB_SLAVE;
        bb_oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arb_q    <= ext_bus_pkg::ARB_SLAVE;
      req_n_q  <= 1'b1;
      bb_oe_q  <= 1'b0;
      bb_out_q <= 1'b1;
    end else begin
      arb_q    <= arb_d;
      req_n_q  <= req_n_d;
      bb_oe_q  <= bb_oe_d;
      bb_out_q <= bb_out_d;
    end
  end

  assign is_master      = (arb_q == ext_bus_pkg::ARB_MASTER);
  assign bus_request_n  = req_n_q;
  assign bus_busy_n_out = bb_out_q;
  assign bus_busy_n_oe  = bb_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus cycle with wait states
  logic ws_load;
  logic ws_expired;
  logic zero_ws_q;
  logic zero_ws_d;

  assign ws_load = (cyc_q == ext_bus_pkg::CYC_IDLE) && is_master && ext_req && !grant_n_s;

  wait_counter #(.W(WAIT_W)) u_wait (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (ws_load),
    .count   (wait_states),
    .expired (ws_expired)
  );

  // cycle sequencing, acknowledge only seen in an active cycle as master
  always_comb begin
    cyc_d     = cyc_q;
    wr_d      = wr_q;
    zero_ws_d = zero_ws_q;
    unique case (cyc_q)
      ext_bus_pkg::CYC_IDLE: begin
        if (ws_load) begin
          cyc_d     = ext_bus_pkg::CYC_WAIT;
          wr_d      = ext_write;
          zero_ws_d = (wait_states == '0);
        end
      end
      ext_bus_pkg::CYC_WAIT: begin
        if (ws_expired) begin
          if (zero_ws_q) begin
            cyc_d = ext_bus_pkg::CYC_DONE;
          end else begin
            cyc_d = ext_bus_pkg::CYC_ACK;
          end
        end
      end
      ext_bus_pkg::CYC_ACK: begin
        // stretch without limit until acknowledge asserted
        if (!ack_n_s) begin
          cyc_d = ext_bus_pkg::CYC_DONE;
        end
      end
      ext_bus_pkg::CYC_DONE: begin
        cyc_d = ext_bus_pkg::CYC_IDLE;
        wr_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cyc_q     <= ext_bus_pkg::CYC_IDLE;
      wr_q      <= 1'b0;
      zero_ws_q <= 1'b0;
    end else begin
      cyc_q     <= cyc_d;
      wr_q      <= wr_d;
      zero_ws_q <= zero_ws_d;
    end
  end

  assign ext_done           = cyc_end;
  // strobe driven only while master
  assign write_strobe_n_oe  = is_master;
  assign write_strobe_n_out = !(wr_q && cyc_active && !cyc_end);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // strobe and bus cycle
  a_strobe_master: assert property (@(posedge clk_sys) disable iff (rst)
    !write_strobe_n_out |-> write_strobe_n_oe)
    else $error("write strobe low while not master");
  a_strobe_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !cyc_active |-> write_strobe_n_out)
    else $error("write strobe low outside a bus cycle");
  a_ack_slave: assert property (@(posedge clk_sys) disable iff (rst)
    (arb_q != ext_bus_pkg::ARB_MASTER) |-> !cyc_active)
    else $error("bus cycle active while not master");
  a_ack_idle: assert property (@(posedge clk_sys) disable iff (rst)
    is_master && !cyc_active && !ws_load |=> !cyc_active)
    else $error("bus cycle started without an access");
  a_ack_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    (cyc_q == ext_bus_pkg::CYC_ACK) && ack_n_s |=> cyc_q == ext_bus_pkg::CYC_ACK)
    else $error("cycle ended without acknowledge");
  a_ack_finish: assert property (@(posedge clk_sys) disable iff (rst)
    (cyc_q == ext_bus_pkg::CYC_ACK) && !ack_n_s |=> ext_done)
    else $error("cycle not done one clock after acknowledge");
  a_done_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    ext_done |=> !ext_done)
    else $error("cycle completion longer than one clock");
  a_zero_ws: assert property (@(posedge clk_sys) disable iff (rst)
    ws_load && (wait_states == '0) |=> ##[1:2] ext_done)
    else $error("zero wait access extended");
  a_min_wait: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(cyc_q == ext_bus_pkg::CYC_ACK) |-> $past(ws_expired))
    else $error("acknowledge phase before programmed waits");

  // request
  a_req_need: assert property (@(posedge clk_sys) disable iff (rst)
    !standby && ext_req |=> !bus_request_n)
    else $error("request not raised for external access");
  a_park_drop: assert property (@(posedge clk_sys) disable iff (rst)
    is_master && !standby && !ext_req && !request_hold |=> bus_request_n)
    else $error("request kept while master without need");
  a_standby_req: assert property (@(posedge clk_sys) disable iff (rst)
    standby && !request_hold |=> bus_request_n)
    else $error("request held in standby without hold bit");
  a_hold_req: assert property (@(posedge clk_sys) disable iff (rst)
    request_hold && !standby |=> !bus_request_n)
    else $error("hold bit did not keep request");
  a_standby_keep: assert property (@(posedge clk_sys) disable iff (rst)
    standby && request_hold |=> bus_request_n == $past(bus_request_n))
    else $error("request changed in standby with hold bit");
  a_reset_state: assert property (@(posedge clk_sys)
    $past(rst) |-> bus_request_n && !is_master && !bus_busy_n_oe)
    else $error("reset left request or mastership");

  // arbitration and busy line
  a_take_busy: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(is_master) |-> $past(busy_n_s) && !bus_busy_n_out && bus_busy_n_oe)
    else $error("mastership taken while bus busy");
  a_grant_wait: assert property (@(posedge clk_sys) disable iff (rst)
    (arb_q == ext_bus_pkg::ARB_WAIT_BB) && !busy_n_s |=> !is_master)
    else $error("mastership taken before busy released");
  a_busy_master: assert property (@(posedge clk_sys) disable iff (rst)
    is_master |-> bus_busy_n_oe && !bus_busy_n_out)
    else $error("busy not driven low while master");
  a_park_hold: assert property (@(posedge clk_sys) disable iff (rst)
    is_master && !grant_n_s |=> is_master)
    else $error("parked mastership lost while granted");
  a_grant_drop: assert property (@(posedge clk_sys) disable iff (rst)
    is_master && grant_n_s && !cyc_active |=> !is_master)
    else $error("mastership kept after grant withdrawn");
  a_release_mid: assert property (@(posedge clk_sys) disable iff (rst)
    is_master && cyc_active && !cyc_end |=> is_master)
    else $error("mastership dropped inside a bus cycle");
  a_release_hi: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(bus_busy_n_oe) |-> $past(bus_busy_n_out))
    else $error("busy released without driving high");
  a_release_drive: assert property (@(posedge clk_sys) disable iff (rst)
    (arb_q == ext_bus_pkg::ARB_RELEASE) |-> bus_busy_n_oe && bus_busy_n_out)
    else $error("busy not driven high on release");
  a_slave_float: assert property (@(posedge clk_sys) disable iff (rst)
    (arb_q == ext_bus_pkg::ARB_SLAVE) |-> !bus_busy_n_oe)
    else $error("busy line driven while slave");

  // synchronisers
  a_ack_synced: assert property (@(posedge clk_sys) disable iff (rst)
    ack_sync_select && $past(transfer_ack_n, 2) |-> ack_n_s)
    else $error("acknowledge seen before two synchroniser stages");
  a_grant_synced: assert property (@(posedge clk_sys) disable iff (rst)
    async_arb_enable && $past(bus_grant_n, 2) |-> grant_n_s)
    else $error("grant seen before two synchroniser stages");

endmodule

//--- bench/ext_partner.sv
`timescale 1ns/1ps
// far side: arbiter, memory responder and a second bus master
module ext_partner (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // bench commands
  input  wire logic       armed,
  input  wire logic [7:0] ack_delay,
  input  wire logic       withhold,
  input  wire logic       other_hold,
  // pins
  input  wire logic       bus_request_n,
  output logic            bus_grant_n,
  output logic            transfer_ack_n,
  output logic            other_oe
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       grant_d;
  logic       ack_d;
  ////////////////////////////////////////////////////////////////////////////
  // grant on request, parked until withheld; ack after delay, 8'hFF never
  always_comb begin
    grant_d = withhold ? 1'b1 : (bus_request_n ? bus_grant_n : 1'b0);
    cnt_d   = armed ? cnt_q + 8'h01 : 8'h00;
    ack_d   = !(armed && ack_delay != 8'hFF && cnt_q >= ack_delay);
  end
  // pins change only on the clock edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_grant_n    <= 1'b1;
      transfer_ack_n <= 1'b1;
      other_oe       <= 1'b0;
      cnt_q          <= 8'h00;
    end else begin
      bus_grant_n    <= grant_d;
      transfer_ack_n <= ack_d;
      other_oe       <= other_hold;
      cnt_q          <= cnt_d;
    end
  end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
// random and corner-case bench of the bus control block
module tb_top;
  logic       clk_sys, rst, rq_hold, ack_sel, arb_en, standby, ext_req, ext_write;
  logic       ext_done, is_master, ack_n, grant_n, busy_w, busy_out, busy_oe;
  logic       req_n, wr_out, wr_oe, armed, withhold, other_hold, other_oe;
  logic [3:0] ws;
  logic [7:0] dly;
  logic [31:0] rnd;
  int         err_count, checked, cyc, lat, m, k;
  ////////////////////////////////////////////////////////////////////////////
  // shared busy line with pull-up
  assign busy_w = !((busy_oe && !busy_out) || other_oe);
  ext_bus_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .wait_states(ws),
    .request_hold(rq_hold), .ack_sync_select(ack_sel), .async_arb_enable(arb_en),
    .standby(standby), .ext_req(ext_req), .ext_write(ext_write), .ext_done(ext_done),
    .is_master(is_master), .transfer_ack_n(ack_n), .bus_grant_n(grant_n),
    .bus_busy_n_in(busy_w), .bus_busy_n_out(busy_out), .bus_busy_n_oe(busy_oe),
    .bus_request_n(req_n), .write_strobe_n_out(wr_out), .write_strobe_n_oe(wr_oe));
  ext_partner u_far (.clk_sys(clk_sys), .rst(rst), .armed(armed), .ack_delay(dly),
    .withhold(withhold), .other_hold(other_hold), .bus_request_n(req_n),
    .bus_grant_n(grant_n), .transfer_ack_n(ack_n), .other_oe(other_oe));
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang limit
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  // random source and helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // cycles from request to done: programmed waits or late acknowledge
  function automatic int exp_lat(input int n, input int d, input logic s);
    int a;
    a = d + (s ? 4 : 2);
    return (n + 3 > a) ? n + 3 : a;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic check_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %0b seen %0b", name, exp, got);
    end
  endtask
  task automatic check_cnt(input string name, input int exp, input int got);
    checked++;
    if (got != exp) begin
      err_count++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one access while master; a stalled one is acked late and loses its grant
  task automatic do_cycle(input logic wr, input logic [3:0] w, input logic [7:0] d);
    ws = w;
    ext_write = wr;
    dly = d;
    ext_req = 1'b1;
    armed = 1'b1;
    lat = 0;
    do begin
      tick(1);
      lat++;
      if (lat == 1) check_bit("strobe", !wr, wr_out);
      if (lat == 1) check_bit("strobe_oe", 1'b1, wr_oe);
      if (lat == 20 && d == 8'hFF) withhold = 1'b1;
      if (lat == 30 && d == 8'hFF) check_bit("held", 1'b1, is_master);
      if (lat == 40 && d == 8'hFF) dly = 8'h00;
    end while (ext_done !== 1'b1 && lat < 200);
    ext_req = 1'b0;
    armed = 1'b0;
    tick(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst, rq_hold, ack_sel, arb_en, standby, ext_req, ext_write} = 7'h41;
    {armed, withhold, other_hold, ws, dly, cyc, err_count, checked} = 0;
    rnd = 32'hEBFE;
    tick(12);
    rst = 1'b0;
    check_bit("req_rst", 1'b1, req_n);
    check_bit("master_rst", 1'b0, is_master);
    check_bit("strobe_oe_rst", 1'b0, wr_oe);
    check_bit("busy_oe_rst", 1'b0, busy_oe);
    armed = 1'b1;
    other_hold = 1'b1;
    ext_req = 1'b1;
    tick(6);
    check_bit("slave_ack", 1'b0, ext_done);
    check_bit("slave_strobe", 1'b1, wr_out);
    ext_req = 1'b0;
    armed = 1'b0;
    for (m = 0; m < 4; m++) begin
      {arb_en, ack_sel} = m[1:0];
      other_hold = 1'b1;
      rq_hold = 1'b1;
      tick(8);
      check_bit("hold_req", 1'b0, req_n);
      check_bit("wait_busy", 1'b0, is_master);
      other_hold = 1'b0;
      for (k = 0; k < 20 && is_master !== 1'b1; k++) tick(1);
      check_bit("take_busy", 1'b0, busy_oe ? busy_out : 1'b1);
      rq_hold = 1'b0;
      armed = 1'b1;
      tick(4);
      check_bit("req_drop", 1'b1, req_n);
      check_bit("parked", 1'b1, is_master && busy_oe);
      check_bit("idle_ack", 1'b0, ext_done);
      armed = 1'b0;
      tick(1);
      for (k = 0; k < 4; k++) begin
        rnd = lfsr(rnd);
        if (k == 0) do_cycle(rnd[4], 4'h0, 8'hFF);
        else if (k < 3) do_cycle(rnd[4], 4'h1 | rnd[3:0], {6'h00, rnd[9:8]});
        else do_cycle(rnd[4], 4'h2, 8'hFF);
        if (k == 0) check_cnt("zero_wait", 2, lat);
        if (k > 0 && k < 3) check_cnt("min_wait", exp_lat(ws, dly, ack_sel), lat);
        if (k == 3) check_cnt("stretch", exp_lat(2, 40, ack_sel), lat);
      end
      for (k = 0; k < 10 && !(busy_oe === 1'b1 && busy_out === 1'b1); k++) tick(1);
      check_bit("drive_high", 1'b1, busy_out && busy_oe);
      tick(2);
      check_bit("float", 1'b0, busy_oe);
      check_bit("released", 1'b0, is_master);
      withhold = 1'b0;
      tick(4);
    end
    rq_hold = 1'b1;
    tick(4);
    standby = 1'b1;
    tick(4);
    check_bit("stby_keep", 1'b0, req_n);
    rq_hold = 1'b0;
    tick(4);
    check_bit("stby_drop", 1'b1, req_n);
    wrap_up();
  end
endmodule
